// ==== timer8_compare_pwm.v ====
// 8-bit timer/counter with two output compare units and PWM
//
// Summary of operation
// - Count and both compare values are 8-bit
// - Each request flagged and individually masked
// - Tick from prescaler or external pin edge
// - Clock select zero stops the counter
// - Bottom 0x00, max 0xFF, top per mode
// - Each tick clears, increments or decrements count
// - Count value readable and writable any time
// - Processor count write beats clear or count
// - Three-bit waveform mode split across two registers
// - Overflow flag set per mode, gated request
// - Equality sets compare flag at next tick
// - Enabled compare flag raises compare request
// - Flag cleared by service or writing one
// - Outputs from match, mode, output mode, extremes
// - Compare values buffered only in PWM modes
// - Buffered value copied only at top/bottom
// - Accesses reach buffer or active register
// - Force strobe acts like match in non-PWM modes only, no flag
// - Count write blocks matches for next tick
// - Normal mode wraps, overflow when count becomes zero
// - Mode 2 clears count on compare A match
// - Fast PWM top 0xFF (3) or compare A (7)
// - Output mode zero takes no output action
`timescale 1ns/1ps
`default_nettype none
`include "timer8_map.vh"

module timer8_compare_pwm (
  input  wire                     clk_sys_i,
  input  wire                     rst_b_i,
  input  wire [2:0]               clock_select_field_i,
  input  wire                     waveform_mode_bit0_i,
  input  wire                     waveform_mode_bit1_i,
  input  wire                     waveform_mode_bit2_i,
  input  wire [1:0]               compare_output_mode_a_i,
  input  wire [1:0]               compare_output_mode_b_i,
  input  wire                     force_compare_bit_a_i,
  input  wire                     force_compare_bit_b_i,
  input  wire                     external_count_pin_i,
  input  wire                     count_value_we_i,
  input  wire [`T8_WIDTH-1:0]     count_value_wdata_i,
  input  wire                     compare_value_a_we_i,
  input  wire [`T8_WIDTH-1:0]     compare_value_a_wdata_i,
  input  wire                     compare_value_b_we_i,
  input  wire [`T8_WIDTH-1:0]     compare_value_b_wdata_i,
  input  wire [`T8_FLAG_WIDTH-1:0] timer_mask_register_i,
  input  wire                     timer_flag_register_we_i,
  input  wire [`T8_FLAG_WIDTH-1:0] timer_flag_register_wdata_i,
  input  wire [`T8_FLAG_WIDTH-1:0] irq_serviced_i,
  output wire [`T8_WIDTH-1:0]     count_value_o,
  output wire [`T8_WIDTH-1:0]     compare_value_a_o,
  output wire [`T8_WIDTH-1:0]     compare_value_b_o,
  output wire [`T8_FLAG_WIDTH-1:0] timer_flag_register_o,
  output wire                     overflow_irq_o,
  output wire                     compare_a_irq_o,
  output wire                     compare_b_irq_o,
  output wire                     compare_out_a_o,
  output wire                     compare_out_b_o,
  output wire                     timer_tick_o
);

  wire [2:0]                waveform_mode_field;
  wire                      timer_tick;
  wire                      mode_fast;
  wire                      mode_phase;
  wire                      mode_pwm;
  wire                      mode_ctc;
  wire                      top_is_ocra;
  wire [`T8_WIDTH-1:0]      top_value;
  wire                      at_top;
  wire                      at_bottom;
  wire                      at_max;
  wire                      advance;
  wire                      buf_load;
  wire [1:0]                cmp_match;
  wire [1:0]                cmp_hit;
  wire [1:0]                force_strobe;
  wire [1:0]                ocr_we;
  wire [2*`T8_WIDTH-1:0]    ocr_wdata;
  wire [3:0]                com_modes;
  wire [`T8_FLAG_WIDTH-1:0] flag_set;
  wire [`T8_FLAG_WIDTH-1:0] flag_clr;

  reg  [`T8_WIDTH-1:0]      count_r;
  reg  [`T8_WIDTH-1:0]      count_nxt;
  reg                       dir_down_r;
  reg                       dir_down_nxt;
  reg                       ovf_event;
  reg                       block_r;
  reg  [`T8_FLAG_WIDTH-1:0] flag_r;
  reg  [`T8_WIDTH-1:0]      ocr_act_r [0:1];
  reg  [`T8_WIDTH-1:0]      ocr_buf_r [0:1];
  reg  [1:0]                oc_r;

  timer8_tick_gen u_tick (
    .clk_sys_i            (clk_sys_i),
    .rst_b_i              (rst_b_i),
    .clock_select_field_i (clock_select_field_i),
    .external_count_pin_i (external_count_pin_i),
    .timer_tick_o         (timer_tick)
  );

  // Mode decode
  assign waveform_mode_field = {waveform_mode_bit2_i, waveform_mode_bit1_i, waveform_mode_bit0_i};
  assign mode_fast   = (waveform_mode_field == `T8_WGM_FAST_MAX) ||
                       (waveform_mode_field == `T8_WGM_FAST_OCRA);
  assign mode_phase  = (waveform_mode_field == `T8_WGM_PC_MAX) ||
                       (waveform_mode_field == `T8_WGM_PC_OCRA);
  assign mode_pwm    = mode_fast | mode_phase;
  assign mode_ctc    = (waveform_mode_field == `T8_WGM_CTC);
  assign top_is_ocra = (waveform_mode_field == `T8_WGM_FAST_OCRA) ||
                       (waveform_mode_field == `T8_WGM_PC_OCRA);

  assign top_value = top_is_ocra ? ocr_act_r[0] : `T8_MAX;
  assign at_top    = (count_r == top_value);
  assign at_bottom = (count_r == `T8_BOTTOM);
  assign at_max    = (count_r == `T8_MAX);
  // A tick that no count write overrides
  assign advance   = timer_tick & ~count_value_we_i;

  // Counter next state
  always @* begin
    count_nxt    = count_r;
    dir_down_nxt = dir_down_r;
    if (count_value_we_i) begin
      count_nxt    = count_value_wdata_i;
    end else if (timer_tick) begin
      // Phase correct turns at top and at bottom
      if (mode_phase) begin
        if (!dir_down_r) begin
          if (at_top) begin
            dir_down_nxt = 1'b1;
            count_nxt    = at_bottom ? count_r : count_r - 8'h01;
          end else begin
            count_nxt    = count_r + 8'h01;
          end
        end else begin
          if (at_bottom) begin
            dir_down_nxt = 1'b0;
            count_nxt    = at_top ? count_r : count_r + 8'h01;
          end else begin
            count_nxt    = count_r - 8'h01;
          end
        end
      end else if (mode_fast) begin
        count_nxt = at_top ? `T8_BOTTOM : count_r + 8'h01;
      end else if (mode_ctc) begin
        count_nxt = (count_r == ocr_act_r[0]) ? `T8_BOTTOM : count_r + 8'h01;
      end else begin
        count_nxt = count_r + 8'h01;
      end
    end
  end

  // Overflow point depends on mode
  always @* begin
    ovf_event = 1'b0;
    if (advance) begin
      if (mode_phase) begin
        ovf_event = dir_down_r & at_bottom;
      end else if (mode_fast) begin
        ovf_event = at_top;
      end else begin
        ovf_event = at_max;
      end
    end
  end

  // Buffered compare values load at bottom (fast) or top (phase correct)
  assign buf_load = advance & at_top &
                    (mode_fast | (mode_phase & ~dir_down_r));

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_r    <= `T8_COUNT_RESET;
      dir_down_r <= 1'b0;
      block_r    <= 1'b0;
    end else begin
      count_r    <= count_nxt;
      dir_down_r <= mode_phase ? dir_down_nxt : 1'b0;
      // Blocks matches up to the next tick, also while stopped
      if (count_value_we_i) begin
        block_r <= 1'b1;
      end else if (timer_tick) begin
        block_r <= 1'b0;
      end
    end
  end

  assign ocr_we    = {compare_value_b_we_i, compare_value_a_we_i};
  assign ocr_wdata = {compare_value_b_wdata_i, compare_value_a_wdata_i};
  assign com_modes = {compare_output_mode_b_i, compare_output_mode_a_i};
  assign force_strobe = {force_compare_bit_b_i, force_compare_bit_a_i};

  // Per compare unit: registers, match and waveform
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
      wire [1:0] com;
      reg        oc_nxt;
      assign com = com_modes[2*gi+1:2*gi];
      assign cmp_match[gi] = (count_r == ocr_act_r[gi]);
      // Match is acted on at the tick after equality, unless blocked
      assign cmp_hit[gi] = advance & cmp_match[gi] & ~block_r;

      always @* begin
        oc_nxt = oc_r[gi];
        if (mode_fast) begin
          if (cmp_hit[gi]) begin
            case (com)
              `T8_COM_TOGGLE: oc_nxt = (gi == 0 && top_is_ocra) ? ~oc_r[gi] : oc_r[gi];
              `T8_COM_CLEAR:  oc_nxt = 1'b0;
              `T8_COM_SET:    oc_nxt = 1'b1;
              default:        oc_nxt = oc_r[gi];
            endcase
          end else if (advance & at_top) begin
            // Restore at bottom; max/top compare keeps output steady
            case (com)
              `T8_COM_CLEAR: oc_nxt = 1'b1;
              `T8_COM_SET:   oc_nxt = 1'b0;
              default:       oc_nxt = oc_r[gi];
            endcase
          end
        end else if (mode_phase) begin
          if (cmp_hit[gi]) begin
            case (com)
              `T8_COM_TOGGLE: oc_nxt = (gi == 0 && top_is_ocra) ? ~oc_r[gi] : oc_r[gi];
              `T8_COM_CLEAR:  oc_nxt = dir_down_r;
              `T8_COM_SET:    oc_nxt = ~dir_down_r;
              default:        oc_nxt = oc_r[gi];
            endcase
          end
        end else if (cmp_hit[gi] | force_strobe[gi]) begin
          case (com)
            `T8_COM_TOGGLE: oc_nxt = ~oc_r[gi];
            `T8_COM_CLEAR:  oc_nxt = 1'b0;
            `T8_COM_SET:    oc_nxt = 1'b1;
            default:        oc_nxt = oc_r[gi];
          endcase
        end
      end

      always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          ocr_act_r[gi] <= `T8_OCR_RESET;
          ocr_buf_r[gi] <= `T8_OCR_RESET;
          oc_r[gi]      <= 1'b0;
        end else begin
          oc_r[gi] <= oc_nxt;
          if (ocr_we[gi]) begin
            ocr_buf_r[gi] <= ocr_wdata[gi*`T8_WIDTH +: `T8_WIDTH];
          end
          // Unbuffered modes write straight through to the active value
          if (ocr_we[gi] & ~mode_pwm) begin
            ocr_act_r[gi] <= ocr_wdata[gi*`T8_WIDTH +: `T8_WIDTH];
          end else if (buf_load) begin
            ocr_act_r[gi] <= ocr_we[gi] ? ocr_wdata[gi*`T8_WIDTH +: `T8_WIDTH] : ocr_buf_r[gi];
          end
        end
      end
    end
  endgenerate

  // Flags: hardware set wins over any clear in the same cycle
  assign flag_set[`T8_FLAG_OVF]  = ovf_event;
  assign flag_set[`T8_FLAG_CMPA] = cmp_hit[0];
  assign flag_set[`T8_FLAG_CMPB] = cmp_hit[1];
  // Cleared by the serviced pulse or by writing a one
  assign flag_clr = irq_serviced_i |
                    (timer_flag_register_we_i ? timer_flag_register_wdata_i : {`T8_FLAG_WIDTH{1'b0}});

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_r <= {`T8_FLAG_WIDTH{1'b0}};
    end else begin
      flag_r <= flag_set | (flag_r & ~flag_clr);
    end
  end

  assign timer_flag_register_o = flag_r;
  // Each request is its flag gated by its own mask bit
  assign overflow_irq_o  = flag_r[`T8_FLAG_OVF]  & timer_mask_register_i[`T8_FLAG_OVF];
  assign compare_a_irq_o = flag_r[`T8_FLAG_CMPA] & timer_mask_register_i[`T8_FLAG_CMPA];
  assign compare_b_irq_o = flag_r[`T8_FLAG_CMPB] & timer_mask_register_i[`T8_FLAG_CMPB];

  assign count_value_o     = count_r;
  // Compare reads see the buffer while buffering is on
  assign compare_value_a_o = mode_pwm ? ocr_buf_r[0] : ocr_act_r[0];
  assign compare_value_b_o = mode_pwm ? ocr_buf_r[1] : ocr_act_r[1];
  assign compare_out_a_o   = oc_r[0];
  assign compare_out_b_o   = oc_r[1];
  assign timer_tick_o      = timer_tick;

endmodule // timer8_compare_pwm
`default_nettype wire

// ==== timer8_map.vh ====
// Constants for the 8-bit timer with two compare units
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH

`define T8_WIDTH          8
`define T8_BOTTOM         8'h00
`define T8_MAX            8'hFF
`define T8_COUNT_RESET    8'h00
`define T8_OCR_RESET      8'h00

`define T8_CS_STOP        3'h0
`define T8_CS_DIV1        3'h1
`define T8_CS_DIV8        3'h2
`define T8_CS_DIV64       3'h3
`define T8_CS_DIV256      3'h4
`define T8_CS_DIV1024     3'h5
`define T8_CS_EXT_FALL    3'h6
`define T8_CS_EXT_RISE    3'h7

`define T8_PRE_WIDTH      10
`define T8_PRE_DIV8       10'h007
`define T8_PRE_DIV64      10'h03F
`define T8_PRE_DIV256     10'h0FF
`define T8_PRE_DIV1024    10'h3FF

`define T8_WGM_NORMAL     3'h0
`define T8_WGM_PC_MAX     3'h1
`define T8_WGM_CTC        3'h2
`define T8_WGM_FAST_MAX   3'h3
`define T8_WGM_PC_OCRA    3'h5
`define T8_WGM_FAST_OCRA  3'h7

`define T8_COM_NONE       2'h0
`define T8_COM_TOGGLE     2'h1
`define T8_COM_CLEAR      2'h2
`define T8_COM_SET        2'h3

`define T8_FLAG_OVF       0
`define T8_FLAG_CMPA      1
`define T8_FLAG_CMPB      2
`define T8_FLAG_WIDTH     3

`endif

// ==== timer8_tick_gen.v ====
// Timer tick source: prescaler taps and synchronised external count pin
`timescale 1ns/1ps
`default_nettype none
`include "timer8_map.vh"

module timer8_tick_gen (
  input  wire       clk_sys_i,
  input  wire       rst_b_i,
  input  wire [2:0] clock_select_field_i,
  input  wire       external_count_pin_i,
  output reg        timer_tick_o
);

  reg  [`T8_PRE_WIDTH-1:0] pre_cnt_r;
  reg                      ext_meta_r;
  reg                      ext_sync_r;
  reg                      ext_prev_r;
  wire                     ext_rise;
  wire                     ext_fall;

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_cnt_r  <= {`T8_PRE_WIDTH{1'b0}};
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      pre_cnt_r  <= pre_cnt_r + {{(`T8_PRE_WIDTH-1){1'b0}}, 1'b1};
      ext_meta_r <= external_count_pin_i;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  // Edge detect reads only the second and third stages
  assign ext_rise = ext_sync_r & ~ext_prev_r;
  assign ext_fall = ~ext_sync_r & ext_prev_r;

  always @* begin
    case (clock_select_field_i)
      `T8_CS_STOP:     timer_tick_o = 1'b0;
      `T8_CS_DIV1:     timer_tick_o = 1'b1;
      `T8_CS_DIV8:     timer_tick_o = ((pre_cnt_r & `T8_PRE_DIV8) == `T8_PRE_DIV8);
      `T8_CS_DIV64:    timer_tick_o = ((pre_cnt_r & `T8_PRE_DIV64) == `T8_PRE_DIV64);
      `T8_CS_DIV256:   timer_tick_o = ((pre_cnt_r & `T8_PRE_DIV256) == `T8_PRE_DIV256);
      `T8_CS_DIV1024:  timer_tick_o = (pre_cnt_r == `T8_PRE_DIV1024);
      `T8_CS_EXT_FALL: timer_tick_o = ext_fall;
      `T8_CS_EXT_RISE: timer_tick_o = ext_rise;
      default:         timer_tick_o = 1'b0;
    endcase
  end

endmodule // timer8_tick_gen
`default_nettype wire

// ==== timer8_compare_pwm_sva.sv ====
// Port-level assertions for the 8-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "timer8_map.vh"
module timer8_compare_pwm_sva (
  input wire logic                      clk_sys_i,
  input wire logic                      rst_b_i,
  input wire logic [2:0]                clock_select_field_i,
  input wire logic                      waveform_mode_bit0_i,
  input wire logic                      waveform_mode_bit1_i,
  input wire logic                      waveform_mode_bit2_i,
  input wire logic                      force_compare_bit_a_i,
  input wire logic                      count_value_we_i,
  input wire logic [`T8_WIDTH-1:0]      count_value_wdata_i,
  input wire logic [`T8_FLAG_WIDTH-1:0] timer_mask_register_i,
  input wire logic                      timer_flag_register_we_i,
  input wire logic [`T8_FLAG_WIDTH-1:0] timer_flag_register_wdata_i,
  input wire logic [`T8_WIDTH-1:0]      count_value_o,
  input wire logic [`T8_WIDTH-1:0]      compare_value_a_o,
  input wire logic [`T8_FLAG_WIDTH-1:0] timer_flag_register_o,
  input wire logic                      overflow_irq_o,
  input wire logic                      compare_a_irq_o,
  input wire logic                      compare_b_irq_o,
  input wire logic                      timer_tick_o
);
  wire [2:0] mode = {waveform_mode_bit2_i, waveform_mode_bit1_i, waveform_mode_bit0_i};
  wire       adv  = timer_tick_o && !count_value_we_i;
  reg        blk_r;
  // Matches blocked from a count write up to the next tick
  always @(posedge clk_sys_i or negedge rst_b_i)
    if (!rst_b_i) blk_r <= 1'h0;
    else if (count_value_we_i) blk_r <= 1'h1;
    else if (timer_tick_o) blk_r <= 1'h0;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_ovf_irq_gate: assert property (overflow_irq_o == (timer_flag_register_o[0] & timer_mask_register_i[0]))
    else $error("overflow request wrong");
  a_cmp_irq_gate: assert property ((compare_a_irq_o == (timer_flag_register_o[1] & timer_mask_register_i[1])) && (compare_b_irq_o == (timer_flag_register_o[2] & timer_mask_register_i[2])))
    else $error("compare request wrong");
  a_stop_no_tick: assert property (clock_select_field_i == `T8_CS_STOP |-> !timer_tick_o)
    else $error("tick while stopped");
  a_write_wins: assert property (count_value_we_i |=> count_value_o == $past(count_value_wdata_i))
    else $error("count write lost");
  a_normal_inc: assert property (mode == `T8_WGM_NORMAL && adv |=> count_value_o == $past(count_value_o) + 8'h01)
    else $error("normal count step wrong");
  a_normal_ovf: assert property (mode == `T8_WGM_NORMAL && adv && count_value_o == `T8_MAX |=> timer_flag_register_o[0])
    else $error("overflow flag missing");
  a_ctc_clear: assert property (mode == `T8_WGM_CTC && adv && !blk_r && count_value_o == compare_value_a_o |=> count_value_o == `T8_BOTTOM)
    else $error("clear on match missing");
  a_match_flag: assert property (!waveform_mode_bit0_i && adv && !blk_r && count_value_o == compare_value_a_o |=> timer_flag_register_o[1])
    else $error("compare flag missing");
  a_block_match: assert property (timer_tick_o && (blk_r || count_value_we_i) && !timer_flag_register_o[1] |=> !timer_flag_register_o[1])
    else $error("blocked match set flag");
  a_force_no_flag: assert property (force_compare_bit_a_i && !timer_tick_o && !timer_flag_register_o[1] |=> !timer_flag_register_o[1])
    else $error("force set flag");
  a_flag_clear: assert property (timer_flag_register_we_i && timer_flag_register_wdata_i[0] && !timer_tick_o |=> !timer_flag_register_o[0])
    else $error("flag not cleared");
endmodule // timer8_compare_pwm_sva
`default_nettype wire

// ==== timer8_compare_pwm_tb.sv ====
// Self-checking bench for the 8-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "timer8_map.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module timer8_compare_pwm_tb;
  logic       clk_sys_i = 1'h0, rst_b_i = 1'h0, external_count_pin_i = 1'h0, count_value_we_i = 1'h0;
  logic       waveform_mode_bit0_i = 1'h0, waveform_mode_bit1_i = 1'h0, waveform_mode_bit2_i = 1'h0;
  logic       force_compare_bit_a_i = 1'h0, force_compare_bit_b_i = 1'h0, timer_flag_register_we_i = 1'h0;
  logic       compare_value_a_we_i = 1'h0, compare_value_b_we_i = 1'h0;
  logic [2:0] clock_select_field_i = 3'h0, timer_mask_register_i = 3'h7;
  logic [2:0] timer_flag_register_wdata_i = 3'h0, irq_serviced_i = 3'h0;
  logic [1:0] compare_output_mode_a_i = 2'h0, compare_output_mode_b_i = 2'h0;
  logic [7:0] count_value_wdata_i = 8'h00, compare_value_a_wdata_i = 8'h00, compare_value_b_wdata_i = 8'h00, c0;
  wire  [7:0] count_value_o, compare_value_a_o, compare_value_b_o;
  wire  [2:0] timer_flag_register_o;
  wire        overflow_irq_o, compare_a_irq_o, compare_b_irq_o, compare_out_a_o, compare_out_b_o, timer_tick_o;
  int         checks = 0, miscompares = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  timer8_compare_pwm i_dut (.clk_sys_i, .rst_b_i, .clock_select_field_i, .waveform_mode_bit0_i,
    .waveform_mode_bit1_i, .waveform_mode_bit2_i, .compare_output_mode_a_i, .compare_output_mode_b_i,
    .force_compare_bit_a_i, .force_compare_bit_b_i, .external_count_pin_i, .count_value_we_i,
    .count_value_wdata_i, .compare_value_a_we_i, .compare_value_a_wdata_i, .compare_value_b_we_i,
    .compare_value_b_wdata_i, .timer_mask_register_i, .timer_flag_register_we_i, .timer_flag_register_wdata_i,
    .irq_serviced_i, .count_value_o, .compare_value_a_o, .compare_value_b_o, .timer_flag_register_o,
    .overflow_irq_o, .compare_a_irq_o, .compare_b_irq_o, .compare_out_a_o, .compare_out_b_o, .timer_tick_o);
  task automatic print_verdict;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic nx(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Register write: 0 count, 1 compare A, 2 compare B
  task automatic wr(input int k, input logic [7:0] v);
    @(posedge clk_sys_i);
    count_value_we_i <= (k == 0);
    compare_value_a_we_i <= (k == 1);
    compare_value_b_we_i <= (k == 2);
    count_value_wdata_i <= v;
    compare_value_a_wdata_i <= v;
    compare_value_b_wdata_i <= v;
    @(posedge clk_sys_i);
    {count_value_we_i, compare_value_a_we_i, compare_value_b_we_i} <= 3'h0;
  endtask
  task automatic clr(input logic [2:0] m);
    @(posedge clk_sys_i);
    timer_flag_register_we_i <= 1'h1;
    timer_flag_register_wdata_i <= m;
    @(posedge clk_sys_i);
    timer_flag_register_we_i <= 1'h0;
  endtask
  task automatic mode(input logic [2:0] m, input logic [2:0] cs);
    @(posedge clk_sys_i);
    {waveform_mode_bit2_i, waveform_mode_bit1_i, waveform_mode_bit0_i} <= m;
    clock_select_field_i <= cs;
  endtask
  task automatic wait_cnt(input logic [7:0] v);
    int i;
    for (i = 0; i < 400 && count_value_o !== v; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (i == 400) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic sc_normal;
    wr(0, 8'hFD);
    mode(`T8_WGM_NORMAL, `T8_CS_DIV1);
    nx(3);
    #1 `CHK(count_value_o, 8'h00)
    `CHK(timer_flag_register_o[0], 1'h1)
    `CHK(overflow_irq_o, 1'h1)
    mode(`T8_WGM_NORMAL, `T8_CS_STOP);
    #1 c0 = count_value_o;
    nx(5);
    #1 `CHK(count_value_o, c0)
    clr(3'h7);
    #1 `CHK(timer_flag_register_o, 3'h0)
  endtask
  task automatic sc_block;
    wr(1, 8'h20);
    compare_output_mode_a_i <= `T8_COM_TOGGLE;
    wr(0, 8'h20);
    mode(`T8_WGM_NORMAL, `T8_CS_DIV1);
    nx(1);
    #1 `CHK(timer_flag_register_o[1], 1'h0)
    `CHK(compare_out_a_o, 1'h0)
    wr(0, 8'h1E);
    nx(2);
    #1 `CHK(timer_flag_register_o[1], 1'h0)
    nx(1);
    #1 `CHK(timer_flag_register_o[1], 1'h1)
    `CHK(compare_out_a_o, 1'h1)
    `CHK(compare_a_irq_o, 1'h1)
    @(posedge clk_sys_i);
    irq_serviced_i <= 3'h2;
    @(posedge clk_sys_i);
    irq_serviced_i <= 3'h0;
    #1 `CHK(timer_flag_register_o[1], 1'h0)
    mode(`T8_WGM_NORMAL, `T8_CS_STOP);
  endtask
  task automatic sc_force;
    logic [1:0] cm[5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1};
    logic       ex[5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys_i);
      compare_output_mode_a_i <= cm[i];
      compare_output_mode_b_i <= cm[i];
      {force_compare_bit_a_i, force_compare_bit_b_i} <= 2'h3;
      @(posedge clk_sys_i);
      {force_compare_bit_a_i, force_compare_bit_b_i} <= 2'h0;
      #1 `CHK(compare_out_a_o, ex[i])
      `CHK(compare_out_b_o, ex[i])
    end
    `CHK(timer_flag_register_o, 3'h0)
  endtask
  task automatic sc_ctc;
    logic [7:0] ex[5] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h01};
    mode(`T8_WGM_CTC, `T8_CS_STOP);
    wr(1, 8'h03);
    wr(2, 8'h41);
    #1 `CHK(compare_value_a_o, 8'h03)
    `CHK(compare_value_b_o, 8'h41)
    wr(0, 8'h00);
    mode(`T8_WGM_CTC, `T8_CS_DIV1);
    for (int i = 0; i < 5; i++) begin
      nx(1);
      #1 `CHK(count_value_o, ex[i])
    end
  endtask
  task automatic sc_fast;
    mode(`T8_WGM_FAST_MAX, `T8_CS_STOP);
    compare_output_mode_a_i <= `T8_COM_CLEAR;
    clr(3'h7);
    wr(1, 8'h10);
    #1 `CHK(compare_value_a_o, 8'h10)
    wr(0, 8'h01);
    mode(`T8_WGM_FAST_MAX, `T8_CS_DIV1);
    nx(3);
    #1 `CHK(timer_flag_register_o[1], 1'h1)
    clr(3'h7);
    wait_cnt(8'h00);
    `CHK(timer_flag_register_o[0], 1'h1)
    `CHK(compare_out_a_o, 1'h1)
    `CHK(compare_b_irq_o, 1'h1)
    wait_cnt(8'h05);
    `CHK(timer_flag_register_o[1], 1'h0)
    wait_cnt(8'h11);
    `CHK(timer_flag_register_o[1], 1'h1)
    `CHK(compare_out_a_o, 1'h0)
    mode(`T8_WGM_FAST_OCRA, `T8_CS_DIV1);
    wait_cnt(8'h10);
    nx(1);
    #1 `CHK(count_value_o, 8'h00)
  endtask
  task automatic sc_phase;
    logic [7:0] ex[4] = '{8'hFF, 8'hFE, 8'hFD, 8'hFC};
    mode(`T8_WGM_PC_MAX, `T8_CS_STOP);
    clr(3'h7);
    wr(0, 8'hFE);
    mode(`T8_WGM_PC_MAX, `T8_CS_DIV1);
    for (int i = 0; i < 4; i++) begin
      nx(1);
      #1 `CHK(count_value_o, ex[i])
    end
    `CHK(timer_flag_register_o[0], 1'h0)
    wr(0, 8'h01);
    nx(2);
    #1 `CHK(count_value_o, 8'h01)
    `CHK(timer_flag_register_o[0], 1'h1)
    mode(`T8_WGM_PC_OCRA, `T8_CS_DIV1);
    wait_cnt(8'h10);
    nx(1);
    #1 `CHK(count_value_o, 8'h0F)
    `CHK(timer_flag_register_o[1], 1'h1)
  endtask
  task automatic sc_ext;
    logic [7:0] ex[4] = '{8'h01, 8'h01, 8'h01, 8'h02};
    mode(`T8_WGM_NORMAL, `T8_CS_EXT_RISE);
    wr(0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) clock_select_field_i <= `T8_CS_EXT_FALL;
      external_count_pin_i <= (k % 2 == 0);
      nx(6);
      #1 `CHK(count_value_o, ex[k])
      @(posedge clk_sys_i);
    end
  endtask
  task automatic sc_presc;
    logic [2:0] cv[4] = '{`T8_CS_DIV8, `T8_CS_DIV64, `T8_CS_DIV256, `T8_CS_DIV1024};
    int         dv[4] = '{8, 64, 256, 1024};
    for (int k = 0; k < 4; k++) begin
      mode(`T8_WGM_NORMAL, cv[k]);
      nx(2);
      #1 c0 = count_value_o;
      nx(dv[k]);
      #1 `CHK(count_value_o - c0, 8'h01)
    end
  endtask
  initial begin
    nx(10);
    rst_b_i <= 1'h1;
    #1 `CHK(count_value_o, 8'h00)
    `CHK(timer_flag_register_o, 3'h0)
    sc_normal();
    sc_block();
    sc_force();
    sc_ctc();
    sc_fast();
    sc_ext();
    sc_presc();
    sc_phase();
    print_verdict();
  end
endmodule // timer8_compare_pwm_tb
bind timer8_compare_pwm timer8_compare_pwm_sva i_sva (.clk_sys_i, .rst_b_i, .clock_select_field_i,
  .waveform_mode_bit0_i, .waveform_mode_bit1_i, .waveform_mode_bit2_i, .force_compare_bit_a_i,
  .count_value_we_i, .count_value_wdata_i, .timer_mask_register_i, .timer_flag_register_we_i,
  .timer_flag_register_wdata_i, .count_value_o, .compare_value_a_o, .timer_flag_register_o,
  .overflow_irq_o, .compare_a_irq_o, .compare_b_irq_o, .timer_tick_o);
`default_nettype wire
